// >>> logic/field_ctrl_options.sv
// field current control options: limits, loop gain modifiers,
// economy switching and firing angle handling behind an APB slave
// assumes all inputs synchronous to pclk; 200 MHz clock
`include "field_ctrl_regs.svh"

module field_ctrl_options #(
  parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drive_enable,
  input  wire logic        full_control_link,
  input  wire logic        early_field_card,
  input  wire logic [9:0]  emf_field_demand,
  input  wire logic [9:0]  loop_firing_angle,
  output logic      [9:0]  field_limit,
  output logic      [9:0]  field_demand,
  output logic      [9:0]  firing_angle,
  output field_ctrl_pkg::loop_cfg_type loop_cfg,
  output logic             ir_source_current,
  output logic      [15:0] speed_gain_factor
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0]  economy_timeout_seconds_reg;
  logic [9:0]  firing_front_endstop_reg;
  logic [9:0]  max_field_1_reg;
  logic [9:0]  max_field_2_reg;
  logic [9:0]  min_field_reg;
  logic [6:0]  scaling_code_reg;
  logic [`CONTROL_BITS_W-1:0] control_bits_reg;
  logic        scaling_reject_reg;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire wr_access = psel & penable & pwrite & clk_en;
  wire rd_setup  = psel & ~penable & ~pwrite;

  function automatic logic hit(input logic [11:0] addr,
                               input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire sel_timeout  = hit(paddr, `OFS_ECONOMY_TIMEOUT);
  wire sel_control  = hit(paddr, `OFS_CONTROL_BITS);
  wire sel_endstop  = hit(paddr, `OFS_FRONT_ENDSTOP);
  wire sel_max1     = hit(paddr, `OFS_MAX_FIELD_1);
  wire sel_max2     = hit(paddr, `OFS_MAX_FIELD_2);
  wire sel_min      = hit(paddr, `OFS_MIN_FIELD);
  wire sel_demand   = hit(paddr, `OFS_FIELD_DEMAND_IN);
  wire sel_status   = hit(paddr, `OFS_STATUS);
  wire sel_scaling  = hit(paddr, `OFS_SCALING_CODE);
  wire sel_any      = sel_timeout | sel_control | sel_endstop |
                      sel_max1 | sel_max2 | sel_min | sel_demand |
                      sel_status | sel_scaling;

  // field and endstop values above 1000 are clipped on write
  function automatic logic [9:0] clip1000(input logic [31:0] v);
    clip1000 = (v > 32'(`FULL_PHASE_FORWARD)) ?
               `FULL_PHASE_FORWARD : v[9:0];
  endfunction

  wire [9:0] wdata_clipped = clip1000(pwdata);
  wire [6:0] wcode         = pwdata[6:0];
  wire       code_ok       = !early_field_card ||
                             ((wcode >= `SCALING_CODE_MIN) &&
                              (wcode <= `SCALING_CODE_MAX));

  // ****************************************************************
  // economy control of the field 2 selector
  // ****************************************************************
  wire economy_on = control_bits_reg[`BIT_ECONOMY_ENABLE];
  wire reduce_field;

  economy_timer #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_economy (
    .pclk            (pclk),
    .presetn         (presetn),
    .clk_en          (clk_en),
    .timer_enable    (economy_on),
    .drive_enable    (drive_enable),
    .timeout_seconds (economy_timeout_seconds_reg),
    .reduce_field    (reduce_field)
  );

  // timer owns the selector when enabled
  wire second_max_sel = economy_on ? reduce_field :
                        control_bits_reg[`BIT_SECOND_MAX];

  // ****************************************************************
  // control register write: timer-owned bit is not user writable
  // ****************************************************************
  logic [`CONTROL_BITS_W-1:0] control_bits_next;
  always_comb begin
    control_bits_next = control_bits_reg;
    if (wr_access && sel_control) begin
      control_bits_next = pwdata[`CONTROL_BITS_W-1:0];
      control_bits_next[`BIT_RESERVED] = 1'b0;
      if (economy_on || pwdata[`BIT_ECONOMY_ENABLE]) begin
        control_bits_next[`BIT_SECOND_MAX] =
          control_bits_reg[`BIT_SECOND_MAX];
      end
    end
  end

  // ****************************************************************
  // register next values
  // ****************************************************************
  wire wr_timeout = wr_access & sel_timeout;
  wire wr_endstop = wr_access & sel_endstop;
  wire wr_max1    = wr_access & sel_max1;
  wire wr_max2    = wr_access & sel_max2;
  wire wr_min     = wr_access & sel_min;
  wire wr_scaling = wr_access & sel_scaling;

  wire [7:0] economy_timeout_seconds_next =
    wr_timeout ? pwdata[7:0] : economy_timeout_seconds_reg;
  wire [9:0] firing_front_endstop_next =
    wr_endstop ? wdata_clipped : firing_front_endstop_reg;
  wire [9:0] max_field_1_next =
    wr_max1 ? wdata_clipped : max_field_1_reg;
  wire [9:0] max_field_2_next =
    wr_max2 ? wdata_clipped : max_field_2_reg;
  wire [9:0] min_field_next =
    wr_min ? wdata_clipped : min_field_reg;
  // out-of-range codes refused on the early card
  wire [6:0] scaling_code_next =
    (wr_scaling && code_ok) ? wcode : scaling_code_reg;
  wire       scaling_reject_next =
    wr_scaling ? !code_ok : scaling_reject_reg;

  // ****************************************************************
  // register processes, one short process per register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_bits_reg <= `RST_CONTROL_BITS;
    end else if (clk_en) begin
      control_bits_reg <= control_bits_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      economy_timeout_seconds_reg <= `RST_ECONOMY_TIMEOUT;
    end else if (clk_en) begin
      economy_timeout_seconds_reg <= economy_timeout_seconds_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      firing_front_endstop_reg <= `RST_FRONT_ENDSTOP;
    end else if (clk_en) begin
      firing_front_endstop_reg <= firing_front_endstop_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_field_1_reg <= `RST_MAX_FIELD_1;
    end else if (clk_en) begin
      max_field_1_reg <= max_field_1_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_field_2_reg <= `RST_MAX_FIELD_2;
    end else if (clk_en) begin
      max_field_2_reg <= max_field_2_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_field_reg <= `RST_MIN_FIELD;
    end else if (clk_en) begin
      min_field_reg <= min_field_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scaling_code_reg <= `RST_SCALING_CODE;
    end else if (clk_en) begin
      scaling_code_reg <= scaling_code_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scaling_reject_reg <= 1'b0;
    end else if (clk_en) begin
      scaling_reject_reg <= scaling_reject_next;
    end
  end

  // ****************************************************************
  // field limits and demand
  // ****************************************************************
  wire [9:0] limit_sel   = second_max_sel ? max_field_2_reg
                                          : max_field_1_reg;
  wire [9:0] demand_hi   = (emf_field_demand > limit_sel) ?
                           limit_sel : emf_field_demand;
  // min wins if it is set above the max limit
  wire [9:0] demand_lim  = (demand_hi < min_field_reg) ?
                           min_field_reg : demand_hi;

  // ****************************************************************
  // firing angle
  // ****************************************************************
  wire       direct_on   = control_bits_reg[`BIT_DIRECT_FIRING];
  // field 2 drives the bridge, no loop protection
  wire [9:0] angle_raw   = direct_on ? max_field_2_reg
                                     : loop_firing_angle;
  // 1000 is fully forward, endstop clamps advance
  wire [9:0] angle_clamp = (angle_raw > firing_front_endstop_reg) ?
                           firing_front_endstop_reg : angle_raw;

  // ****************************************************************
  // loop configuration
  // ****************************************************************
  wire halve   = control_bits_reg[`BIT_GAIN_HALVE];
  wire quarter = control_bits_reg[`BIT_GAIN_QUARTER];
  // shift of 1, 2 or 3 gives 2, 4 or 8
  wire [2:0] gain_shift = {1'b0, quarter, halve};

  field_ctrl_pkg::loop_cfg_type cfg_next;
  always_comb begin
    cfg_next.field_gain_shift = gain_shift;
    cfg_next.field_int_boost  =
      ~control_bits_reg[`BIT_FIELD_INT_NORMAL];
    cfg_next.volt_int_double  =
      control_bits_reg[`BIT_VOLT_INT_DOUBLE];
    cfg_next.ir_from_current  = control_bits_reg[`BIT_IR_SOURCE];
    // full control only with the external link set
    cfg_next.full_control     =
      control_bits_reg[`BIT_FULL_CONTROL] & full_control_link;
    cfg_next.bypass_loops     = direct_on;
    cfg_next.speed_gain_adj   = control_bits_reg[`BIT_SPEED_GAIN_ADJ];
    cfg_next.field_enable     = control_bits_reg[`BIT_FIELD_ENABLE];
  end

  // speed gain in 8.8 fixed point; divider kept combinational
  // since the option updates at control tick rates
  wire [17:0] gain_quot  = (demand_lim == 10'h000) ? 18'h00100 :
                           ({max_field_1_reg, 8'h00} /
                            {8'h00, demand_lim});
  wire [15:0] gain_sat   = (gain_quot > 18'h0FFFF) ? 16'hFFFF
                                                   : gain_quot[15:0];
  wire [15:0] gain_next  = cfg_next.speed_gain_adj ? gain_sat
                                                   : 16'h0100;

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [31:0] status_word = {26'h0, scaling_reject_reg,
                             cfg_next.full_control, direct_on,
                             reduce_field, second_max_sel,
                             drive_enable};
  wire [`CONTROL_BITS_W-1:0] control_view =
    {control_bits_reg[`CONTROL_BITS_W-1:2], second_max_sel,
     control_bits_reg[0]};

  wire [31:0] rd_word =
    sel_timeout ? {24'h0, economy_timeout_seconds_reg} :
    sel_control ? {20'h0, control_view} :
    sel_endstop ? {22'h0, firing_front_endstop_reg} :
    sel_max1    ? {22'h0, max_field_1_reg} :
    sel_max2    ? {22'h0, max_field_2_reg} :
    sel_min     ? {22'h0, min_field_reg} :
    sel_demand  ? {22'h0, demand_lim} :
    sel_status  ? status_word :
    sel_scaling ? {25'h0, scaling_code_reg} : 32'h0;

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata            <= 32'h0;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end else if (clk_en) begin
      // no wait states: pready rises in the first access cycle
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~sel_any;
      if (rd_setup) begin
        prdata <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_limit       <= `RST_MAX_FIELD_1;
      field_demand      <= `RST_MIN_FIELD;
      firing_angle      <= 10'h000;
      loop_cfg          <= '0;
      ir_source_current <= 1'b0;
      speed_gain_factor <= 16'h0100;
    end else if (clk_en) begin
      field_limit       <= limit_sel;
      field_demand      <= demand_lim;
      firing_angle      <= angle_clamp;
      loop_cfg          <= cfg_next;
      ir_source_current <= cfg_next.ir_from_current;
      speed_gain_factor <= gain_next;
    end
  end

endmodule

// >>> logic/field_ctrl_regs.svh
// register offsets, reset values and timing constants for the
// field current control options block; assumes 200 MHz pclk, APB
`ifndef FIELD_CTRL_REGS_SVH
`define FIELD_CTRL_REGS_SVH

`define OFS_ECONOMY_TIMEOUT   12'h000
`define OFS_CONTROL_BITS      12'h004
`define OFS_FRONT_ENDSTOP     12'h008
`define OFS_MAX_FIELD_1       12'h00C
`define OFS_MAX_FIELD_2       12'h010
`define OFS_MIN_FIELD         12'h014
`define OFS_FIELD_DEMAND_IN   12'h018
`define OFS_STATUS            12'h01C
`define OFS_SCALING_CODE      12'h020

`define RST_ECONOMY_TIMEOUT   8'h1E
`define RST_FRONT_ENDSTOP     10'h3E8
`define RST_MAX_FIELD_1       10'h3E8
`define RST_MAX_FIELD_2       10'h1F4
`define RST_MIN_FIELD         10'h1F4
`define RST_SCALING_CODE      7'h65
`define RST_CONTROL_BITS      12'h010

`define FULL_PHASE_FORWARD    10'h3E8
`define SCALING_CODE_MIN      7'h65
`define SCALING_CODE_MAX      7'h6E

// control bit positions within the control register
`define BIT_FIELD_ENABLE      0
`define BIT_SECOND_MAX        1
`define BIT_ECONOMY_ENABLE    2
`define BIT_FIELD_INT_NORMAL  4
`define BIT_VOLT_INT_DOUBLE   5
`define BIT_SPEED_GAIN_ADJ    6
`define BIT_DIRECT_FIRING     7
`define BIT_IR_SOURCE         8
`define BIT_FULL_CONTROL      9
`define BIT_GAIN_HALVE        10
`define BIT_GAIN_QUARTER      11
`define BIT_RESERVED          3
`define CONTROL_BITS_W        12

`define CLOCK_HZ              200000000
`define SECOND_CYCLES         (`CLOCK_HZ)

`endif

// >>> logic/field_ctrl_pkg.sv
// types shared by the field current control option files
// assumes the register header is included by users of the constants
package field_ctrl_pkg;

  typedef struct packed {
    logic       field_enable;
    logic       second_max_user;
    logic       economy_enable;
    logic       field_int_normal;
    logic       volt_int_double;
    logic       speed_gain_adj;
    logic       direct_firing;
    logic       ir_source;
    logic       full_control;
    logic       gain_halve;
    logic       gain_quarter;
  } control_type;

  typedef struct packed {
    logic [2:0] field_gain_shift;
    logic       field_int_boost;
    logic       volt_int_double;
    logic       ir_from_current;
    logic       full_control;
    logic       bypass_loops;
    logic       speed_gain_adj;
    logic       field_enable;
  } loop_cfg_type;

  typedef enum logic [1:0] {
    ECON_RUN,
    ECON_COUNT,
    ECON_REDUCED
  } economy_state_type;

endpackage

// >>> logic/economy_timer.sv
// economy timer: counts whole seconds while the drive is disabled
// assumes drive_enable is synchronous to pclk
`include "field_ctrl_regs.svh"

module economy_timer #(
  parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       timer_enable,
  input  wire logic       drive_enable,
  input  wire logic [7:0] timeout_seconds,
  output logic            reduce_field
);

  field_ctrl_pkg::economy_state_type state_reg;
  field_ctrl_pkg::economy_state_type state_next;
  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  logic [7:0]  secs_reg;
  logic [7:0]  secs_next;

  wire second_done = (tick_reg == SECOND_CYCLES - 1);
  wire expired     = (secs_reg >= timeout_seconds);

  always_comb begin
    state_next = state_reg;
    tick_next  = tick_reg;
    secs_next  = secs_reg;
    // re-enable clears the timer and restores field 1
    if (!timer_enable || drive_enable) begin
      state_next = field_ctrl_pkg::ECON_RUN;
      tick_next  = '0;
      secs_next  = '0;
    end else begin
      unique case (state_reg)
        field_ctrl_pkg::ECON_RUN: begin
          state_next = field_ctrl_pkg::ECON_COUNT;
        end
        field_ctrl_pkg::ECON_COUNT: begin
          // zero seconds means switch at once
          if (expired) begin
            state_next = field_ctrl_pkg::ECON_REDUCED;
          end else if (second_done) begin
            tick_next = '0;
            secs_next = secs_reg + 8'h01;
          end else begin
            tick_next = tick_reg + 32'h1;
          end
        end
        field_ctrl_pkg::ECON_REDUCED: begin
          state_next = field_ctrl_pkg::ECON_REDUCED;
        end
        default: begin
          state_next = field_ctrl_pkg::ECON_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= field_ctrl_pkg::ECON_RUN;
      tick_reg  <= '0;
      secs_reg  <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      secs_reg  <= secs_next;
    end
  end

  assign reduce_field = (state_reg == field_ctrl_pkg::ECON_REDUCED);

endmodule

// >>> test/field_ctrl_monitor.sv
// checker for the field control options block
// assumes clk_en is held high while it watches
`include "field_ctrl_regs.svh"

module field_ctrl_monitor (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         full_control_link,
  input wire logic [9:0]                   loop_firing_angle,
  input wire logic [9:0]                   firing_angle,
  input wire field_ctrl_pkg::loop_cfg_type loop_cfg,
  input wire logic                         ir_source_current,
  input wire logic [15:0]                  speed_gain_factor
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_answer_first: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_angle_top: assert property (
    firing_angle <= `FULL_PHASE_FORWARD)
    else $error("firing angle above full forward");
  a_angle_loop: assert property (!loop_cfg.bypass_loops &&
    !$past(loop_cfg.bypass_loops) |->
    firing_angle <= $past(loop_firing_angle))
    else $error("firing angle exceeds loop angle");
  a_full_link: assert property (loop_cfg.full_control |->
    $past(full_control_link))
    else $error("full control without link");
  a_ir_same: assert property (
    ir_source_current == loop_cfg.ir_from_current)
    else $error("ir source outputs disagree");
  a_gain_shift: assert property (loop_cfg.field_gain_shift <= 3'h3)
    else $error("gain shift beyond divide by eight");
  a_speed_unity: assert property (!loop_cfg.speed_gain_adj &&
    !$past(loop_cfg.speed_gain_adj) |-> speed_gain_factor == 16'h0100)
    else $error("speed gain not unity while off");
endmodule

bind field_ctrl_options field_ctrl_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .full_control_link(full_control_link),
  .loop_firing_angle(loop_firing_angle), .firing_angle(firing_angle),
  .loop_cfg(loop_cfg), .ir_source_current(ir_source_current),
  .speed_gain_factor(speed_gain_factor));

// >>> test/field_ctrl_options_bench.sv
// bench for the field control options block
// assumes a 200 MHz pclk; a second is shortened to SEC cycles
`include "field_ctrl_regs.svh"

module field_ctrl_options_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // stimulus and checks
  // ****
  localparam int unsigned SEC = 10;
  // control word with link in bit 12, and expected loop config
  localparam logic [12:0] CTL [11] = '{13'h0011, 13'h0000, 13'h0030,
    13'h0110, 13'h0210, 13'h1210, 13'h0410, 13'h0810, 13'h0C10,
    13'h0090, 13'h0050};
  localparam logic [9:0]  EXP [11] = '{10'h001, 10'h040, 10'h020,
    10'h010, 10'h000, 10'h008, 10'h080, 10'h100, 10'h180,
    10'h004, 10'h002};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        drive_enable, full_control_link, early_field_card, rerr;
  logic        ir_source_current, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0]  emf_field_demand, loop_firing_angle;
  logic [9:0]  field_limit, field_demand, firing_angle;
  logic [15:0] speed_gain_factor;
  field_ctrl_pkg::loop_cfg_type loop_cfg;
  int          num_errors, num_checks;

  field_ctrl_options #(.SECOND_CYCLES(SEC)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_enable(drive_enable), .full_control_link(full_control_link),
    .early_field_card(early_field_card),
    .emf_field_demand(emf_field_demand),
    .loop_firing_angle(loop_firing_angle), .field_limit(field_limit),
    .field_demand(field_demand), .firing_angle(firing_angle),
    .loop_cfg(loop_cfg), .ir_source_current(ir_source_current),
    .speed_gain_factor(speed_gain_factor));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; waits for pready with no cap
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    #40us;
    num_errors++;
    stop_test();
  end

  initial begin
    {psel, penable, pwrite, drive_enable, full_control_link} = 5'h00;
    early_field_card = 1'b0;
    clk_en = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    emf_field_demand = 10'h000;
    loop_firing_angle = 10'h000;
    presetn = 1'b0;
    tick(8);
    presetn <= 1'b1;
    tick(1);
    chk(field_limit, 32'h3E8);
    chk(speed_gain_factor, 32'h100);
    rc(`OFS_ECONOMY_TIMEOUT, 32'h1E);
    rc(`OFS_CONTROL_BITS, 32'h010);
    rc(`OFS_FRONT_ENDSTOP, 32'h3E8);
    rc(`OFS_MAX_FIELD_2, 32'h1F4);
    apb(1'b1, 12'h024, 32'h5);
    rc(12'h024, 32'h0);
    chk(rerr, 32'h1);
    $display("test done: reset values");
    apb(1'b1, `OFS_MAX_FIELD_2, 32'h12C);
    apb(1'b1, `OFS_MIN_FIELD, 32'h064);
    apb(1'b1, `OFS_CONTROL_BITS, 32'h012);
    emf_field_demand <= 10'h320;
    tick(3);
    chk(field_limit, 32'h12C);
    chk(field_demand, 32'h12C);
    rc(`OFS_CONTROL_BITS, 32'h012);
    emf_field_demand <= 10'h032;
    tick(3);
    chk(field_demand, 32'h064);
    apb(1'b1, `OFS_CONTROL_BITS, 32'h010);
    tick(3);
    chk(field_limit, 32'h3E8);
    $display("test done: field selector");
    apb(1'b1, `OFS_ECONOMY_TIMEOUT, 32'h2);
    drive_enable <= 1'b1;
    apb(1'b1, `OFS_CONTROL_BITS, 32'h014);
    // a user write to the selector must not win while automatic
    apb(1'b1, `OFS_CONTROL_BITS, 32'h016);
    tick(3);
    chk(field_limit, 32'h3E8);
    drive_enable <= 1'b0;
    tick(15);
    chk(field_limit, 32'h3E8);
    tick(15);
    chk(field_limit, 32'h12C);
    drive_enable <= 1'b1;
    tick(4);
    chk(field_limit, 32'h3E8);
    drive_enable <= 1'b0;
    tick(15);
    drive_enable <= 1'b1;
    tick(2);
    drive_enable <= 1'b0;
    tick(15);
    chk(field_limit, 32'h3E8);
    drive_enable <= 1'b1;
    apb(1'b1, `OFS_ECONOMY_TIMEOUT, 32'hFF);
    rc(`OFS_ECONOMY_TIMEOUT, 32'hFF);
    $display("test done: economy timer");
    for (int i = 0; i < 11; i++) begin
      full_control_link <= CTL[i][12];
      apb(1'b1, `OFS_CONTROL_BITS, {20'h0, CTL[i][11:0]});
      tick(3);
      chk(loop_cfg, EXP[i]);
      chk(ir_source_current, CTL[i][8]);
    end
    $display("test done: control bits");
    emf_field_demand <= 10'h1F4;
    tick(4);
    chk(speed_gain_factor, 32'h200);
    emf_field_demand <= 10'h0FA;
    tick(4);
    chk(speed_gain_factor, 32'h400);
    // a low clock enable must hold every output
    clk_en <= 1'b0;
    emf_field_demand <= 10'h1F4;
    tick(4);
    chk(speed_gain_factor, 32'h400);
    clk_en <= 1'b1;
    tick(4);
    chk(speed_gain_factor, 32'h200);
    $display("test done: speed gain");
    apb(1'b1, `OFS_FRONT_ENDSTOP, 32'h258);
    apb(1'b1, `OFS_MAX_FIELD_2, 32'h12C);
    apb(1'b1, `OFS_CONTROL_BITS, 32'h010);
    loop_firing_angle <= 10'h384;
    tick(3);
    chk(firing_angle, 32'h258);
    loop_firing_angle <= 10'h190;
    tick(3);
    chk(firing_angle, 32'h190);
    apb(1'b1, `OFS_CONTROL_BITS, 32'h090);
    tick(3);
    chk(firing_angle, 32'h12C);
    apb(1'b1, `OFS_MAX_FIELD_2, 32'h320);
    tick(3);
    chk(firing_angle, 32'h258);
    apb(1'b1, `OFS_FRONT_ENDSTOP, 32'h4B0);
    rc(`OFS_FRONT_ENDSTOP, 32'h3E8);
    apb(1'b1, `OFS_CONTROL_BITS, 32'h010);
    loop_firing_angle <= 10'h3FF;
    tick(3);
    chk(firing_angle, 32'h3E8);
    $display("test done: firing angle");
    early_field_card <= 1'b1;
    apb(1'b1, `OFS_SCALING_CODE, 32'h64);
    rc(`OFS_SCALING_CODE, 32'h65);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdata[5], 32'h1);
    apb(1'b1, `OFS_SCALING_CODE, 32'h6E);
    rc(`OFS_SCALING_CODE, 32'h6E);
    apb(1'b1, `OFS_SCALING_CODE, 32'h6F);
    rc(`OFS_SCALING_CODE, 32'h6E);
    $display("test done: scaling code");
    stop_test();
  end
endmodule
